// [core/gcc_pkg.sv]
// Constants, layouts and types of the global channel control block
package gcc_pkg;

  // ----------------------------------------------------------------
  // Register map
  // ----------------------------------------------------------------
  localparam int ADDR_W = 8;
  localparam int DATA_W = 32;
  localparam int CH_NUM = 6;
  localparam logic [ADDR_W-1:0] OFF_RELOAD = 8'h00;
  localparam logic [ADDR_W-1:0] OFF_CURRENT = 8'h04;
  localparam logic [ADDR_W-1:0] OFF_CONTROL = 8'h08;
  localparam logic [DATA_W-1:0] RELOAD_RST = 32'h0000_0000;
  localparam logic [DATA_W-1:0] CURRENT_RST = 32'h0000_0000;

  // ----------------------------------------------------------------
  // Control word fields
  // ----------------------------------------------------------------
  localparam int RSV_LSB = 27;
  localparam int RSV_W = 5;
  localparam int TRIG_BIT = 26;
  localparam int DONE_BIT = 25;
  localparam int TMR_TRIG_BIT = 24;
  localparam int SEL_LSB = 18;
  localparam int PRL_LSB = 12;
  localparam int IC_LSB = 0;
  localparam int IC_W = 2 * CH_NUM;
  localparam logic [1:0] IC_SERIAL = 2'h1;
  localparam logic [1:0] IC_COUNTER = 2'h2;
  localparam logic [CH_NUM-1:0] CH_NONE = 6'h00;
  localparam logic [IC_W-1:0] IC_RST = 12'h000;

  // ----------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    GRP_IDLE = 2'h0,
    GRP_CONV = 2'h1,
    GRP_VALID = 2'h3
  } gcc_grp_state_type;

  typedef struct packed {
    logic [CH_NUM-1:0] start;
    logic [CH_NUM-1:0] abort;
    logic [CH_NUM-1:0] load;
    logic [CH_NUM-1:0] clear;
  } gcc_chan_cmd_type;

  typedef struct packed {
    logic [CH_NUM-1:0] serial_en;
    logic [CH_NUM-1:0] counter_en;
    logic [IC_W-1:0] select;
  } gcc_chan_mode_type;

endpackage : gcc_pkg

// [core/gcc_global_channel_control.sv]
// Global channel control register bank with grouped-read sequencer
`timescale 1ns/1ps
`default_nettype none
module gcc_global_channel_control (
  input wire logic core_clk_i,
  input wire logic rst_n_i,
  input wire logic ce_i,
  input wire logic psel_i,
  input wire logic penable_i,
  input wire logic pwrite_i,
  input wire logic [gcc_pkg::ADDR_W-1:0] paddr_i,
  input wire logic [gcc_pkg::DATA_W-1:0] pwdata_i,
  output logic [gcc_pkg::DATA_W-1:0] prdata_o,
  output logic pready_o,
  output logic pslverr_o,
  input wire logic timer_run_i,
  input wire logic [gcc_pkg::CH_NUM-1:0] chan_ref_mode_i,
  input wire logic [gcc_pkg::CH_NUM-1:0] chan_conv_done_i,
  input wire logic [gcc_pkg::CH_NUM-1:0] chan_data_read_i,
  input wire logic [gcc_pkg::CH_NUM-1:0] counter_load_req_i,
  input wire logic [gcc_pkg::CH_NUM-1:0] counter_clear_req_i,
  output gcc_pkg::gcc_chan_cmd_type chan_cmd_o,
  output gcc_pkg::gcc_chan_mode_type chan_mode_o,
  output logic timer_expire_o
);

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  function automatic logic [gcc_pkg::CH_NUM-1:0] ic_match(
    input logic [gcc_pkg::IC_W-1:0] ic,
    input logic [1:0] code
  );
    logic [gcc_pkg::CH_NUM-1:0] m;
    m = gcc_pkg::CH_NONE;
    for (int i = 0; i < gcc_pkg::CH_NUM; i++) begin
      m[i] = (ic[2*i +: 2] == code);
    end
    return m;
  endfunction : ic_match

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  logic [gcc_pkg::DATA_W-1:0] reload_reg;
  logic [gcc_pkg::DATA_W-1:0] current_reg;
  logic [gcc_pkg::DATA_W-1:0] prdata_reg;
  logic pready_reg;
  logic pslverr_reg;
  logic tmr_trig_en_reg;
  logic [gcc_pkg::CH_NUM-1:0] sel_reg;
  logic [gcc_pkg::IC_W-1:0] ic_reg;
  gcc_pkg::gcc_grp_state_type grp_state_reg;
  gcc_pkg::gcc_grp_state_type grp_state_next;
  logic [gcc_pkg::CH_NUM-1:0] active_reg;
  logic [gcc_pkg::CH_NUM-1:0] active_next;
  logic [gcc_pkg::CH_NUM-1:0] pend_reg;
  logic [gcc_pkg::CH_NUM-1:0] pend_next;
  gcc_pkg::gcc_chan_cmd_type cmd_reg;
  gcc_pkg::gcc_chan_cmd_type cmd_next;
  gcc_pkg::gcc_chan_mode_type mode_reg;
  logic expire_reg;

  // ----------------------------------------------------------------
  // Bus decode
  // ----------------------------------------------------------------
  wire logic bus_take = psel_i & penable_i & ~pready_reg;
  wire logic bus_commit = psel_i & penable_i & pready_reg;
  wire logic bus_wr = bus_commit & pwrite_i;
  wire logic hit_reload = (paddr_i == gcc_pkg::OFF_RELOAD);
  wire logic hit_current = (paddr_i == gcc_pkg::OFF_CURRENT);
  wire logic hit_control = (paddr_i == gcc_pkg::OFF_CONTROL);
  wire logic hit_any = hit_reload | hit_current | hit_control;
  wire logic wr_reload = bus_wr & hit_reload;
  wire logic wr_control = bus_wr & hit_control;
  wire logic sw_trig = wr_control & pwdata_i[gcc_pkg::TRIG_BIT];
  wire logic sw_abort = wr_control & pwdata_i[gcc_pkg::DONE_BIT];
  wire logic [gcc_pkg::CH_NUM-1:0] prl_bits =
    pwdata_i[gcc_pkg::PRL_LSB +: gcc_pkg::CH_NUM];

  wire logic done_bit = (grp_state_reg == gcc_pkg::GRP_VALID);
  // Trigger and preload bits are write pulses, never stored
  wire logic [gcc_pkg::DATA_W-1:0] control_word = {
    {gcc_pkg::RSV_W{1'b0}}, 1'b0, done_bit, tmr_trig_en_reg,
    sel_reg, gcc_pkg::CH_NONE, ic_reg};
  wire logic [gcc_pkg::DATA_W-1:0] read_word =
    hit_reload ? reload_reg :
    hit_current ? current_reg :
    hit_control ? control_word : '0;

  // ----------------------------------------------------------------
  // Interval timer
  // ----------------------------------------------------------------
  wire logic timer_zero = (current_reg == '0);
  wire logic timer_expire = timer_run_i & timer_zero;
  wire logic [gcc_pkg::DATA_W-1:0] current_next =
    timer_expire ? reload_reg :
    timer_run_i ? current_reg - 32'h0000_0001 : current_reg;

  // ----------------------------------------------------------------
  // Grouped read
  // ----------------------------------------------------------------
  // Only serial channels take part; select bits held before this write
  wire logic [gcc_pkg::CH_NUM-1:0] eligible =
    sel_reg & mode_reg.serial_en;
  wire logic any_trig = sw_trig |
    (tmr_trig_en_reg & timer_expire);
  wire logic grp_start = any_trig & ~sw_abort & (eligible != '0);
  wire logic [gcc_pkg::CH_NUM-1:0] conv_acc =
    pend_reg & ~chan_conv_done_i;
  wire logic [gcc_pkg::CH_NUM-1:0] read_acc =
    pend_reg & ~chan_data_read_i;

  always_comb begin
    grp_state_next = grp_state_reg;
    active_next = active_reg;
    pend_next = pend_reg;
    if (sw_abort) begin
      grp_state_next = gcc_pkg::GRP_IDLE;
      active_next = gcc_pkg::CH_NONE;
      pend_next = gcc_pkg::CH_NONE;
    end else if (grp_start) begin
      // A new trigger wins over a read finishing in the same cycle
      grp_state_next = gcc_pkg::GRP_CONV;
      active_next = eligible;
      pend_next = eligible;
    end else begin
      case (grp_state_reg)
        gcc_pkg::GRP_CONV: begin
          pend_next = conv_acc;
          if (conv_acc == '0) begin
            grp_state_next = gcc_pkg::GRP_VALID;
            pend_next = active_reg;
          end
        end
        gcc_pkg::GRP_VALID: begin
          pend_next = read_acc;
          if (read_acc == '0) begin
            grp_state_next = gcc_pkg::GRP_IDLE;
            active_next = gcc_pkg::CH_NONE;
          end
        end
        default: begin
          grp_state_next = gcc_pkg::GRP_IDLE;
        end
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Channel commands
  // ----------------------------------------------------------------
  always_comb begin
    cmd_next.start = grp_start ? eligible : gcc_pkg::CH_NONE;
    cmd_next.abort = sw_abort ? active_reg : gcc_pkg::CH_NONE;
    // Preload ignored for channels outside reference mode
    cmd_next.load = (wr_control ? prl_bits & chan_ref_mode_i
                     : gcc_pkg::CH_NONE) | counter_load_req_i;
    cmd_next.clear = counter_clear_req_i;
  end

  // ----------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------
  always_ff @(posedge core_clk_i) begin
    if (!rst_n_i) begin
      pready_reg <= 1'b0;
      pslverr_reg <= 1'b0;
      prdata_reg <= '0;
    end else if (ce_i) begin
      pready_reg <= bus_take;
      pslverr_reg <= bus_take & ~hit_any;
      prdata_reg <= (bus_take & ~pwrite_i) ? read_word : '0;
    end
  end

  always_ff @(posedge core_clk_i) begin
    if (!rst_n_i) begin
      reload_reg <= gcc_pkg::RELOAD_RST;
      current_reg <= gcc_pkg::CURRENT_RST;
      expire_reg <= 1'b0;
    end else if (ce_i) begin
      if (wr_reload) begin
        reload_reg <= pwdata_i;
      end
      current_reg <= current_next;
      expire_reg <= timer_expire;
    end
  end

  always_ff @(posedge core_clk_i) begin
    if (!rst_n_i) begin
      tmr_trig_en_reg <= 1'b0;
      sel_reg <= gcc_pkg::CH_NONE;
      ic_reg <= gcc_pkg::IC_RST;
    end else if (ce_i && wr_control) begin
      tmr_trig_en_reg <= pwdata_i[gcc_pkg::TMR_TRIG_BIT];
      sel_reg <= pwdata_i[gcc_pkg::SEL_LSB +: gcc_pkg::CH_NUM];
      ic_reg <= pwdata_i[gcc_pkg::IC_LSB +: gcc_pkg::IC_W];
    end
  end

  always_ff @(posedge core_clk_i) begin
    if (!rst_n_i) begin
      grp_state_reg <= gcc_pkg::GRP_IDLE;
      active_reg <= gcc_pkg::CH_NONE;
      pend_reg <= gcc_pkg::CH_NONE;
      cmd_reg <= '0;
      mode_reg <= '0;
    end else if (ce_i) begin
      grp_state_reg <= grp_state_next;
      active_reg <= active_next;
      pend_reg <= pend_next;
      cmd_reg <= cmd_next;
      mode_reg.serial_en <= ic_match(ic_reg, gcc_pkg::IC_SERIAL);
      mode_reg.counter_en <= ic_match(ic_reg, gcc_pkg::IC_COUNTER);
      mode_reg.select <= ic_reg;
    end
  end

  assign prdata_o = prdata_reg;
  assign pready_o = pready_reg;
  assign pslverr_o = pslverr_reg;
  assign chan_cmd_o = cmd_reg;
  assign chan_mode_o = mode_reg;
  assign timer_expire_o = expire_reg;

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge core_clk_i); endclocking
  default disable iff (!rst_n_i);

  sequence s_abort_wr;
    ce_i && sw_abort;
  endsequence
  sequence s_idle_after;
    grp_state_reg == gcc_pkg::GRP_IDLE && pend_reg == '0;
  endsequence

  property p_reload_wr;
    ce_i && wr_reload |=> reload_reg == $past(pwdata_i);
  endproperty
  a_reload_wr: assert property (p_reload_wr)
    else $error("reload value not stored");

  property p_timer_reload;
    ce_i && timer_expire |=> current_reg == $past(reload_reg)
      && expire_reg;
  endproperty
  a_timer_reload: assert property (p_timer_reload)
    else $error("timer did not restart from reload");

  property p_trig_start;
    ce_i && sw_trig && !sw_abort && eligible != '0
      |=> cmd_reg.start == $past(eligible)
      && grp_state_reg == gcc_pkg::GRP_CONV;
  endproperty
  a_trig_start: assert property (p_trig_start)
    else $error("trigger did not start selected channels");

  property p_old_sel;
    ce_i |=> (cmd_reg.start & ~$past(sel_reg)) == '0;
  endproperty
  a_old_sel: assert property (p_old_sel)
    else $error("start reached channel not selected beforehand");

  property p_done_set;
    ce_i && !sw_abort && !grp_start
      && grp_state_reg == gcc_pkg::GRP_CONV && conv_acc == '0
      |=> done_bit && pend_reg == $past(active_reg);
  endproperty
  a_done_set: assert property (p_done_set)
    else $error("done bit not set after conversions");

  property p_done_clear;
    ce_i && !sw_abort && !grp_start && done_bit && read_acc == '0
      |=> s_idle_after;
  endproperty
  a_done_clear: assert property (p_done_clear)
    else $error("done bit not cleared after reads");

  property p_abort;
    s_abort_wr |=> s_idle_after and (cmd_reg.abort == $past(active_reg));
  endproperty
  a_abort: assert property (p_abort)
    else $error("abort did not reset sequence");

  property p_timer_gate;
    ce_i && !tmr_trig_en_reg && !sw_trig |=> cmd_reg.start == '0;
  endproperty
  a_timer_gate: assert property (p_timer_gate)
    else $error("timer triggered while disabled");

  property p_preload;
    ce_i && wr_control |=> cmd_reg.load ==
      (($past(prl_bits) & $past(chan_ref_mode_i))
       | $past(counter_load_req_i));
  endproperty
  a_preload: assert property (p_preload)
    else $error("preload reached wrong channels");

  property p_rsv_read;
    ce_i && bus_take && !pwrite_i && hit_control
      |=> prdata_reg[gcc_pkg::DATA_W-1:gcc_pkg::DONE_BIT+1] == '0
      && prdata_reg[gcc_pkg::PRL_LSB +: gcc_pkg::CH_NUM] == '0;
  endproperty
  a_rsv_read: assert property (p_rsv_read)
    else $error("reserved or pulse bits read non-zero");

endmodule : gcc_global_channel_control
`default_nettype wire

// [testbench/gcc_chan_model.sv]
// Behavioural model of the per-channel serial conversion engines
`timescale 1ns/1ps
`default_nettype none
module gcc_chan_model #(
  parameter int CONV_CYC = 16
) (
  input wire logic core_clk_i,
  input wire logic rst_n_i,
  input wire gcc_pkg::gcc_chan_cmd_type chan_cmd_i,
  output logic [gcc_pkg::CH_NUM-1:0] conv_done_o
);
  int cnt [gcc_pkg::CH_NUM];
  // ----------------------------------------------------------------
  // Conversion timers
  // ----------------------------------------------------------------
  always @(posedge core_clk_i) begin
    for (int i = 0; i < gcc_pkg::CH_NUM; i++) begin
      conv_done_o[i] <= 1'b0;
      if (!rst_n_i || chan_cmd_i.abort[i]) begin
        cnt[i] <= 0;
      end else if (chan_cmd_i.start[i]) begin
        cnt[i] <= CONV_CYC;
      end else if (cnt[i] > 0) begin
        cnt[i] <= cnt[i] - 1;
        conv_done_o[i] <= (cnt[i] == 1);
      end
    end
  end
endmodule : gcc_chan_model
`default_nettype wire

// [testbench/testbench.sv]
// Self-checking bench of the global channel control block
`timescale 1ns/1ps
`default_nettype none
module testbench;
  typedef struct {
    logic wr;
    logic [7:0] a;
    logic [31:0] d;
    logic [31:0] exp;
    logic err;
  } gcc_row_type;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic psel = 1'b0, pen = 1'b0, pwrite = 1'b0, trun = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0, prdata, r;
  logic pready, pslverr, expire, e;
  logic [5:0] ref_m = 6'h00, rd = 6'h00, ldq = 6'h00, clq = 6'h00, done;
  logic [5:0] st_s, ab_s, ld_s, cl_s;
  logic exp_s;
  gcc_pkg::gcc_chan_cmd_type cmd;
  gcc_pkg::gcc_chan_mode_type mode;
  int error_cnt = 0;
  int samples_checked = 0;
  gcc_row_type rows [10] = '{
    '{1, 8'h00, 32'h1234_5678, 32'h0, 0}, '{0, 8'h00, 0, 32'h1234_5678, 0},
    '{1, 8'h04, 32'hffff_ffff, 32'h0, 0}, '{0, 8'h04, 0, 32'h0, 0},
    '{1, 8'h08, 32'hffff_ffff, 32'h0, 0}, '{0, 8'h08, 0, 32'h01fc_0fff, 0},
    '{1, 8'h0c, 32'h5, 32'h0, 1}, '{0, 8'h0c, 0, 32'h0, 1},
    '{1, 8'h08, 32'h0, 32'h0, 0}, '{0, 8'h08, 0, 32'h0, 0}};

  always #20 clk = ~clk;

  gcc_global_channel_control dut (
    .core_clk_i(clk), .rst_n_i(rst_n), .ce_i(1'b1),
    .psel_i(psel), .penable_i(pen), .pwrite_i(pwrite),
    .paddr_i(paddr), .pwdata_i(pwdata), .prdata_o(prdata),
    .pready_o(pready), .pslverr_o(pslverr), .timer_run_i(trun),
    .chan_ref_mode_i(ref_m), .chan_conv_done_i(done),
    .chan_data_read_i(rd), .counter_load_req_i(ldq),
    .counter_clear_req_i(clq), .chan_cmd_o(cmd), .chan_mode_o(mode),
    .timer_expire_o(expire));
  gcc_chan_model #(.CONV_CYC(16)) engines (
    .core_clk_i(clk), .rst_n_i(rst_n), .chan_cmd_i(cmd),
    .conv_done_o(done));

  // ----------------------------------------------------------------
  // Sticky monitors of command and timer expire pulses
  // ----------------------------------------------------------------
  always @(posedge clk) begin
    st_s <= st_s | cmd.start;
    ab_s <= ab_s | cmd.abort;
    ld_s <= ld_s | cmd.load;
    cl_s <= cl_s | cmd.clear;
    exp_s <= exp_s | expire;
  end

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  task clear_seen();
    @(negedge clk);
    {st_s, ab_s, ld_s, cl_s, exp_s} = '0;
    // Back on the rising edge so bus drives stay edge aligned
    @(posedge clk);
  endtask : clear_seen

  task check(input logic ok, input string m);
    samples_checked++;
    if (ok !== 1'b1) begin
      error_cnt++;
      $display("mismatch t=%0t %s", $time, m);
    end
  endtask : check

  task apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    psel <= 1'b1; pwrite <= wr; paddr <= a; pwdata <= d;
    @(posedge clk);
    pen <= 1'b1;
    @(posedge clk);
    while (pready !== 1'b1 && n < 20) begin
      @(posedge clk);
      n++;
    end
    check(n < 20, "no pready");
    r = prdata;
    e = pslverr;
    psel <= 1'b0;
    pen <= 1'b0;
    @(posedge clk);
  endtask : apb

  task wait_cyc(input int n);
    repeat (n) @(posedge clk);
  endtask : wait_cyc

  task give_verdict();
    $display("checks %0d mismatches %0d", samples_checked, error_cnt);
    if (error_cnt == 0 && samples_checked > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask : give_verdict

  initial begin
    #(40 * 5000);
    error_cnt++;
    give_verdict();
  end

  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial begin
    wait_cyc(4);
    rst_n <= 1'b1;
    @(posedge clk);
    check(cmd === '0 && mode === '0 && pready === 1'b0 &&
          expire === 1'b0 && prdata === '0 && pslverr === 1'b0,
          "reset outs");
    foreach (rows[i]) begin
      apb(rows[i].wr, rows[i].a, rows[i].d);
      if (rows[i].wr) check(e === rows[i].err, "row err");
      else check(r === rows[i].exp && e === rows[i].err, "row");
    end
    // Select written in the same write as the trigger does not start; a later trigger does
    apb(1, 8'h08, 32'h0000_0019);
    wait_cyc(2);
    check(mode.serial_en === 6'h05 && mode.counter_en === 6'h02 &&
          mode.select === 12'h019, "ic");
    clear_seen();
    apb(1, 8'h08, 32'h0414_0019);
    wait_cyc(2);
    check(st_s === 6'h00, "same-write trigger");
    apb(1, 8'h08, 32'h0414_0019);
    wait_cyc(20);
    check(st_s === 6'h05, "start mask");
    apb(0, 8'h08, 0);
    check(r === 32'h0214_0019, "done set");
    rd <= 6'h01;
    @(posedge clk);
    rd <= 6'h00;
    apb(0, 8'h08, 0);
    check(r === 32'h0214_0019, "done early clear");
    rd <= 6'h04;
    @(posedge clk);
    rd <= 6'h00;
    apb(0, 8'h08, 0);
    check(r === 32'h0014_0019, "done clear");
    clear_seen();
    apb(1, 8'h08, 32'h0414_0019);
    apb(1, 8'h08, 32'h0214_0019);
    wait_cyc(20);
    apb(0, 8'h08, 0);
    check(ab_s === 6'h05 && r === 32'h0014_0019, "abort");
    // Preload pulses reach only the channels in reference mode
    ref_m <= 6'h05;
    clear_seen();
    apb(1, 8'h08, 32'h0017_f019);
    wait_cyc(1);
    check(ld_s === 6'h05, "preload");
    apb(0, 8'h08, 0);
    check(r === 32'h0014_0019, "preload bits read");
    clear_seen();
    ldq <= 6'h02;
    clq <= 6'h08;
    @(posedge clk);
    ldq <= 6'h00;
    clq <= 6'h00;
    wait_cyc(2);
    check(ld_s === 6'h02 && cl_s === 6'h08, "load clear");
    apb(1, 8'h00, 32'h3);
    apb(1, 8'h08, 32'h0114_0019);
    clear_seen();
    trun <= 1'b1;
    wait_cyc(10);
    check(st_s === 6'h05 && exp_s === 1'b1, "timer trigger");
    apb(0, 8'h04, 0);
    check(r <= 32'h3, "current value");
    apb(1, 8'h08, 32'h0014_0019);
    clear_seen();
    wait_cyc(12);
    check(st_s === 6'h00 && exp_s === 1'b1, "timer disabled");
    trun <= 1'b0;
    // Reset in mid-run must bring every register back
    rst_n <= 1'b0;
    wait_cyc(2);
    rst_n <= 1'b1;
    @(posedge clk);
    check(cmd === '0 && mode === '0 && expire === 1'b0 &&
          pready === 1'b0, "mid reset outs");
    apb(0, 8'h00, 0);
    check(r === 32'h0, "mid reset reload");
    apb(0, 8'h04, 0);
    check(r === 32'h0, "mid reset current");
    apb(0, 8'h08, 0);
    check(r === 32'h0, "mid reset control");
    give_verdict();
  end
endmodule : testbench
`default_nettype wire
